// ### common/clk_pwr_pkg.sv
/*
  Constants, field layouts and carrier types for the clock and power control unit.
  Assumes a 40 MHz system clock and an APB register bus with 32-bit data.
*/
// Notes on behaviour
// - PLL locks to the 32.768 kHz crystal, giving a stable 4.096 MHz clock.
// - Core clock is the PLL clock divided by two to the divider code.
// - Divider resets to 010, core clock 1.024 MHz.
// - Metering clock is the PLL clock divided by five, fixed.
// - Power control write is accepted only right after key 0xA7.
// - Key 0xEA unlocks one write to pin config or time counters.
// - Lock loss resets the core and sets the fault flag, bit 4.
// - Acknowledge bit in the ADC start register clears the fault flag.
// - Power control bit 6 switches off metering circuitry.
// - Power control bit 4 in battery mode shuts the core down.
// - Receive edge waking from sleep sets config bit 7.
// - Config bit 6 shows supply source, one for main, resets to one.
// - Config bit 5 shows main supply adequate, resets to one.
// - Config bit 3 keeps the reference enabled in sleep.
// - Receive pin function: 00 GPIO, 01 receive, 11 receive with wake.
// - Acknowledge control is bit 7 of the ADC start register.

package clk_pwr_pkg;

  // ----------------------------------------------------------------
  // Register indices, taken from paddr[9:2] (printed offsets are indices).
  // ----------------------------------------------------------------
  localparam logic [7:0]  KEY_IDX      = 8'hC1;
  localparam logic [7:0]  PWR_IDX      = 8'hC5;
  localparam logic [7:0]  ADC_START_REGISTER_IDX    = 8'hD8;
  localparam logic [7:0]  PERIPHERAL_CONFIG_STATUS_IDX   = 8'hF4;
  localparam logic [7:0]  INTPIN_IDX   = 8'hFF;
  localparam logic [7:0]  HUND_IDX     = 8'hA2;
  localparam logic [7:0]  SEC_IDX      = 8'hA3;
  localparam logic [7:0]  MIN_IDX      = 8'hA4;
  localparam logic [7:0]  HOUR_IDX     = 8'hA5;
  localparam logic [7:0]  IRQ_STAT_IDX = 8'hE0;
  localparam logic [7:0]  IRQ_MASK_IDX = 8'hE1;

  // ----------------------------------------------------------------
  // Key values and reset values.
  // ----------------------------------------------------------------
  localparam logic [7:0]  KEY_POWER    = 8'hA7;
  localparam logic [7:0]  KEY_TIME     = 8'hEA;
  localparam logic [7:0]  KEY_RST      = 8'h00;
  localparam logic [7:0]  PWR_RST      = 8'h82;
  localparam logic [2:0]  DIV_RST      = 3'h2;
  localparam logic [7:0]  INTPIN_RST   = 8'h00;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int          PWR_METER_BIT = 6;
  localparam int          PWR_CORE_BIT  = 4;
  localparam int          PER_RXW_BIT   = 7;
  localparam int          PER_SRC_BIT   = 6;
  localparam int          PER_OK_BIT    = 5;
  localparam int          PER_FLT_BIT   = 4;
  localparam int          PER_REF_BIT   = 3;
  localparam int          ACK_BIT       = 7;

  // Receive pin functions.
  localparam logic [1:0]  RX_GPIO      = 2'h0;
  localparam logic [1:0]  RX_NOWAKE    = 2'h1;
  localparam logic [1:0]  RX_WAKE      = 2'h3;

  // Interrupt status bits: lock fault, receive wake, supply drop.
  localparam int          IRQ_W        = 3;

  // Metering divider.
  localparam logic [2:0]  METER_DIV    = 3'h5;

  // PLL: 4.096 MHz is 125 times 32.768 kHz.
  localparam logic [6:0]  PLL_MULT     = 7'h7D;

  // Core power states.
  typedef enum logic [1:0] {
    PS_RUN   = 2'b00,
    PS_RESET = 2'b01,
    PS_OFF   = 2'b10
  } core_state_t;

  // Analog status inputs travelling together.
  typedef struct packed {
    logic pll_locked;
    logic main_supply;
    logic main_ok;
    logic battery_mode;
    logic sleep_mode;
    logic rx_edge;
  } analog_status_t;

  // Power control outputs travelling together.
  typedef struct packed {
    logic [2:0] core_div;
    logic       metering_shutdown;
    logic       core_off;
    logic       core_reset;
    logic       ref_sleep_en;
    logic [1:0] rx_func;
  } power_ctl_t;

endpackage

// ### hw/clk_pwr_ctrl.sv
/*
  Clock and power control unit: key-protected power control register,
  peripheral configuration and status, lock fault handling, core and
  metering clock enables derived from the 4.096 MHz PLL clock tick.
  Assumes the PLL clock appears as a one-cycle tick in the 40 MHz domain
  and that the analog status inputs are synchronous to clk.
*/
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module clk_pwr_ctrl (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic                               pready,
  output logic [31:0]                        prdata,
  output logic                               pslverr,
  // PLL and analog status
  input  wire logic                          pll_tick,
  input  wire clk_pwr_pkg::analog_status_t   status_in,
  // Controls to the rest of the chip
  output clk_pwr_pkg::power_ctl_t            ctl_out,
  output logic                               core_clk_en,
  output logic                               meter_clk_en,
  output logic                               time_wr_en,
  output logic [7:0]                         time_wr_idx,
  output logic [7:0]                         time_wr_data,
  output logic                               irq
);

  // ----------------------------------------------------------------
  // Bus decode.
  // ----------------------------------------------------------------
  logic                       wr_acc;
  logic                       rd_acc;
  logic [7:0]                 idx;
  logic [7:0]                 wbyte;
  logic                       addr_ok;
  logic [7:0]                 key_q;
  logic [7:0]                 pwr_q;
  logic [7:0]                 intpin_q;
  logic                       unlock_pwr_q;
  logic                       unlock_time_q;
  logic                       rxw_q;
  logic                       flt_q;
  logic                       ref_q;
  logic [1:0]                 rxf_q;
  logic [clk_pwr_pkg::IRQ_W-1:0] stat_q;
  logic [clk_pwr_pkg::IRQ_W-1:0] mask_q;
  logic [clk_pwr_pkg::IRQ_W-1:0] ev;
  logic                       lock_q;
  logic                       ok_q;
  logic                       lock_loss;
  logic                       ack_wr;
  logic                       time_hit;
  logic [7:0]                 peripheral_config_status_rd;
  logic [7:0]                 rd_byte;
  logic [2:0]                 div_cnt_q;
  logic [6:0]                 core_cnt_q;
  clk_pwr_pkg::core_state_t   cst_q;

  // A write lands only at the edge where pready is seen high, so it lands once.
  // Reads are looked up one cycle earlier, so that prdata stands with pready.
  assign wr_acc = psel & penable & pwrite & pready;
  assign rd_acc = psel & penable & ~pwrite;
  assign idx    = paddr[9:2];
  assign wbyte  = pwdata[7:0];
  assign time_hit = (idx == clk_pwr_pkg::INTPIN_IDX) | (idx == clk_pwr_pkg::HUND_IDX) |
                    (idx == clk_pwr_pkg::SEC_IDX) | (idx == clk_pwr_pkg::MIN_IDX) |
                    (idx == clk_pwr_pkg::HOUR_IDX);
  assign ack_wr = wr_acc & (idx == clk_pwr_pkg::ADC_START_REGISTER_IDX) & wbyte[clk_pwr_pkg::ACK_BIT];
  assign lock_loss = lock_q & ~status_in.pll_locked;

  // Known address set; anything else answers with an error.
  always_comb begin
    unique case (idx)
      clk_pwr_pkg::KEY_IDX, clk_pwr_pkg::PWR_IDX, clk_pwr_pkg::ADC_START_REGISTER_IDX,
      clk_pwr_pkg::PERIPHERAL_CONFIG_STATUS_IDX, clk_pwr_pkg::IRQ_STAT_IDX,
      clk_pwr_pkg::IRQ_MASK_IDX: addr_ok = (paddr[11:10] == 2'h0) & (paddr[1:0] == 2'h0);
      default: addr_ok = time_hit & (paddr[11:10] == 2'h0) & (paddr[1:0] == 2'h0);
    endcase
  end

  // ----------------------------------------------------------------
  // Key register and one-shot unlocks.
  // ----------------------------------------------------------------
  // Any write clears a pending unlock, so only the very next write can use it.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      key_q         <= clk_pwr_pkg::KEY_RST;
      unlock_pwr_q  <= 1'b0;
      unlock_time_q <= 1'b0;
    end else if (wr_acc) begin
      unlock_pwr_q  <= 1'b0;
      unlock_time_q <= 1'b0;
      if (idx == clk_pwr_pkg::KEY_IDX) begin
        key_q         <= wbyte;
        unlock_pwr_q  <= (wbyte == clk_pwr_pkg::KEY_POWER);
        unlock_time_q <= (wbyte == clk_pwr_pkg::KEY_TIME);
      end
    end
  end

  // Power control: bit 7 reads one, bit 3 reads zero, bit 5 stored as written.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_q <= clk_pwr_pkg::PWR_RST;
    end else if (wr_acc && idx == clk_pwr_pkg::PWR_IDX && unlock_pwr_q) begin
      pwr_q <= {1'b1, wbyte[6:4], 1'b0, wbyte[2:0]};
    end
  end

  // Interrupt pin configuration and the time write port share the time key.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      intpin_q     <= clk_pwr_pkg::INTPIN_RST;
      time_wr_en   <= 1'b0;
      time_wr_idx  <= 8'h00;
      time_wr_data <= 8'h00;
    end else begin
      time_wr_en <= wr_acc & time_hit & unlock_time_q;
      if (wr_acc && time_hit) begin
        time_wr_idx  <= idx;
        time_wr_data <= wbyte;
      end
      if (wr_acc && idx == clk_pwr_pkg::INTPIN_IDX && unlock_time_q) begin
        intpin_q <= wbyte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Peripheral configuration and status.
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_q <= 1'b0;
      rxf_q <= clk_pwr_pkg::RX_GPIO;
    end else if (wr_acc && idx == clk_pwr_pkg::PERIPHERAL_CONFIG_STATUS_IDX) begin
      ref_q <= wbyte[clk_pwr_pkg::PER_REF_BIT];
      rxf_q <= wbyte[1:0];
    end
  end

  // Fault and wake flags: a new event wins over a clear in the same cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_q <= 1'b0;
      flt_q  <= 1'b0;
      rxw_q  <= 1'b0;
      ok_q   <= 1'b1;
    end else begin
      lock_q <= status_in.pll_locked;
      ok_q   <= status_in.main_ok;
      if (lock_loss) begin
        flt_q <= 1'b1;
      end else if (ack_wr) begin
        flt_q <= 1'b0;
      end
      if (status_in.sleep_mode && status_in.rx_edge && rxf_q == clk_pwr_pkg::RX_WAKE) begin
        rxw_q <= 1'b1;
      end else if (wr_acc && idx == clk_pwr_pkg::PERIPHERAL_CONFIG_STATUS_IDX && !wbyte[clk_pwr_pkg::PER_RXW_BIT]) begin
        rxw_q <= 1'b0;
      end
    end
  end

  // Status read view: source and health follow the supply monitor live.
  always_comb begin
    peripheral_config_status_rd = {rxw_q, status_in.main_supply, status_in.main_ok, flt_q, ref_q, 1'b0, rxf_q};
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask.
  // ----------------------------------------------------------------
  assign ev = {ok_q & ~status_in.main_ok,
               status_in.sleep_mode & status_in.rx_edge & (rxf_q == clk_pwr_pkg::RX_WAKE),
               lock_loss};

  generate
    for (genvar i = 0; i < clk_pwr_pkg::IRQ_W; i++) begin : g_irq
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          stat_q[i] <= 1'b0;
          mask_q[i] <= 1'b0;
        end else begin
          if (ev[i]) begin
            stat_q[i] <= 1'b1;
          end else if (wr_acc && idx == clk_pwr_pkg::IRQ_STAT_IDX && wbyte[i]) begin
            stat_q[i] <= 1'b0;
          end
          if (wr_acc && idx == clk_pwr_pkg::IRQ_MASK_IDX) begin
            mask_q[i] <= wbyte[i];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Read data and handshake.
  // ----------------------------------------------------------------
  always_comb begin
    unique case (idx)
      clk_pwr_pkg::KEY_IDX:      rd_byte = key_q;
      clk_pwr_pkg::PWR_IDX:      rd_byte = pwr_q;
      clk_pwr_pkg::PERIPHERAL_CONFIG_STATUS_IDX:   rd_byte = peripheral_config_status_rd;
      clk_pwr_pkg::INTPIN_IDX:   rd_byte = intpin_q;
      clk_pwr_pkg::IRQ_STAT_IDX: rd_byte = {5'h00, stat_q};
      clk_pwr_pkg::IRQ_MASK_IDX: rd_byte = {5'h00, mask_q};
      default:                   rd_byte = 8'h00;
    endcase
  end

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      prdata  <= (rd_acc & ~pready & addr_ok) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Clock enables from the PLL tick.
  // ----------------------------------------------------------------
  // Metering divides by five regardless of the core divider.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_q    <= 3'h0;
      meter_clk_en <= 1'b0;
    end else begin
      meter_clk_en <= 1'b0;
      if (pll_tick && status_in.pll_locked) begin
        if (div_cnt_q == clk_pwr_pkg::METER_DIV - 3'h1) begin
          div_cnt_q    <= 3'h0;
          meter_clk_en <= ~pwr_q[clk_pwr_pkg::PWR_METER_BIT];
        end else begin
          div_cnt_q <= div_cnt_q + 3'h1;
        end
      end
    end
  end

  // Core enable fires once every two-to-the-divider PLL ticks.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      core_cnt_q  <= 7'h00;
      core_clk_en <= 1'b0;
    end else begin
      core_clk_en <= 1'b0;
      if (pll_tick && status_in.pll_locked) begin
        if ((core_cnt_q & ((7'h01 << pwr_q[2:0]) - 7'h01)) == 7'h00) begin
          core_clk_en <= (cst_q == clk_pwr_pkg::PS_RUN);
        end
        core_cnt_q <= core_cnt_q + 7'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core power state.
  // ----------------------------------------------------------------
  // Lock loss holds the core in reset until the PLL locks again.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cst_q <= clk_pwr_pkg::PS_RUN;
    end else begin
      unique case (cst_q)
        clk_pwr_pkg::PS_RUN: begin
          if (lock_loss) begin
            cst_q <= clk_pwr_pkg::PS_RESET;
          end else if (pwr_q[clk_pwr_pkg::PWR_CORE_BIT] && status_in.battery_mode) begin
            cst_q <= clk_pwr_pkg::PS_OFF;
          end
        end
        clk_pwr_pkg::PS_RESET: begin
          if (status_in.pll_locked) begin
            cst_q <= clk_pwr_pkg::PS_RUN;
          end
        end
        clk_pwr_pkg::PS_OFF: begin
          // A lock loss must still reset a core that is switched off.
          if (lock_loss) begin
            cst_q <= clk_pwr_pkg::PS_RESET;
          end else if (!pwr_q[clk_pwr_pkg::PWR_CORE_BIT] || !status_in.battery_mode) begin
            cst_q <= clk_pwr_pkg::PS_RUN;
          end
        end
        default: cst_q <= clk_pwr_pkg::PS_RUN;
      endcase
    end
  end

  // Registered control outputs.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_out <= '{core_div: clk_pwr_pkg::DIV_RST, default: 1'b0};
    end else begin
      ctl_out.core_div     <= pwr_q[2:0];
      ctl_out.metering_shutdown    <= pwr_q[clk_pwr_pkg::PWR_METER_BIT];
      ctl_out.core_off     <= (cst_q == clk_pwr_pkg::PS_OFF);
      ctl_out.core_reset   <= (cst_q == clk_pwr_pkg::PS_RESET) | lock_loss;
      ctl_out.ref_sleep_en <= ref_q;
      ctl_out.rx_func      <= rxf_q;
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  pwr_key_a: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(pwr_q) |-> $past(wr_acc && idx == clk_pwr_pkg::PWR_IDX && unlock_pwr_q))
    else $error("Power control changed without key.");
  unlock_once_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_acc && idx != clk_pwr_pkg::KEY_IDX |=> !unlock_pwr_q && !unlock_time_q)
    else $error("Unlock survived a write.");
  time_key_a: assert property (@(posedge clk) disable iff (!arst_n)
    time_wr_en |-> $past(unlock_time_q && wr_acc && time_hit))
    else $error("Timekeeping write without key.");
  fault_set_a: assert property (@(posedge clk) disable iff (!arst_n)
    lock_loss |=> flt_q && cst_q == clk_pwr_pkg::PS_RESET ##1 ctl_out.core_reset)
    else $error("Lock loss not handled.");
  fault_ack_a: assert property (@(posedge clk) disable iff (!arst_n)
    ack_wr && !lock_loss |=> !flt_q)
    else $error("Fault flag not acknowledged.");
  meter_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    pwr_q[clk_pwr_pkg::PWR_METER_BIT] && $past(pwr_q[clk_pwr_pkg::PWR_METER_BIT]) |-> !meter_clk_en)
    else $error("Metering clock runs while off.");
  core_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    cst_q == clk_pwr_pkg::PS_RUN && !lock_loss && pwr_q[clk_pwr_pkg::PWR_CORE_BIT]
      && status_in.battery_mode |=> cst_q == clk_pwr_pkg::PS_OFF ##1 ctl_out.core_off)
    else $error("Core not shut down.");
  rx_wake_a: assert property (@(posedge clk) disable iff (!arst_n)
    status_in.sleep_mode && status_in.rx_edge && rxf_q == clk_pwr_pkg::RX_WAKE |=> rxw_q)
    else $error("Receive wake flag not set.");
  // Bus handshake: exactly one wait state, and an error only together with pready.
  apb_wait_a: assert property (@(posedge clk) disable iff (!arst_n)
    psel && penable && !pready |=> pready)
    else $error("Access not answered after one wait state.");
  apb_err_a: assert property (@(posedge clk) disable iff (!arst_n)
    pslverr |-> pready)
    else $error("Error response without pready.");
  // Interrupt output follows the unmasked status with one register delay.
  irq_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    irq == $past(|(stat_q & mask_q)))
    else $error("Interrupt level does not follow status.");
  // No clock enable leaves the unit while the PLL is out of lock.
  lock_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    !status_in.pll_locked |=> !core_clk_en && !meter_clk_en)
    else $error("Clock enable while PLL unlocked.");
  // Reads never move the one-shot unlocks; only writes consume them.
  unlock_rd_a: assert property (@(posedge clk) disable iff (!arst_n)
    !wr_acc |=> $stable(unlock_pwr_q) && $stable(unlock_time_q))
    else $error("Unlock changed without a write.");

endmodule

`default_nettype wire

// ### sim/test_pll_core_clock_power_control.sv
/*
  Self-checking bench for the clock and power control unit.
  Assumes the design package is compiled first; the bench drives APB, PLL tick and status.
*/
`timescale 1ns/1ps
`default_nettype none

module test_pll_core_clock_power_control;
  // ----------------------------------------------------------------
  // Signals and register aliases
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY = clk_pwr_pkg::KEY_IDX;
  localparam logic [7:0] PWR = clk_pwr_pkg::PWR_IDX;
  localparam logic [7:0] PER = clk_pwr_pkg::PERIPHERAL_CONFIG_STATUS_IDX;
  localparam logic [7:0] STA = clk_pwr_pkg::IRQ_STAT_IDX;
  localparam logic [7:0] MSK = clk_pwr_pkg::IRQ_MASK_IDX;
  logic                        clk, arst_n, psel, penable, pwrite, err, w;
  logic                        pll_tick = 1'b0;
  logic                        pready, pslverr, core_clk_en, meter_clk_en, time_wr_en, irq;
  logic [11:0]                 paddr;
  logic [31:0]                 pwdata, prdata;
  logic [7:0]                  time_wr_idx, time_wr_data, rd, tw_idx, tw_dat, ix;
  logic [3:0]                  tdiv = 4'h0;
  int                          error_cnt, cmp_count, core_n, meter_n, tw_n, c0, m0, t0;
  clk_pwr_pkg::analog_status_t st;
  clk_pwr_pkg::power_ctl_t     ctl;

  clk_pwr_ctrl DUT (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pll_tick(pll_tick), .status_in(st), .ctl_out(ctl),
    .core_clk_en(core_clk_en), .meter_clk_en(meter_clk_en), .time_wr_en(time_wr_en),
    .time_wr_idx(time_wr_idx), .time_wr_data(time_wr_data), .irq(irq));

  // Clock at 40 MHz.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // PLL tick every tenth clock; pulse counters watch the enables and keyed writes.
  always @(posedge clk) begin
    tdiv <= (tdiv == 4'h9) ? 4'h0 : tdiv + 4'h1;
    pll_tick <= (tdiv == 4'h9);
    if (core_clk_en === 1'b1) core_n++;
    if (meter_clk_en === 1'b1) meter_n++;
    if (time_wr_en === 1'b1) begin
      tw_n++;
      tw_idx = time_wr_idx;
      tw_dat = time_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Count check with one pulse of slack, since the tick phase is free-running.
  task automatic rng(input string nm, input int exp, input int got);
    cmp_count++;
    if (got < exp - 1 || got > exp + 1) begin
      error_cnt++;
      $display("BAD %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  // One APB transfer; an idle edge first keeps psel from being driven twice in a step.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("BAD pready expected 1 seen 0");
      conclude();
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(nm, exp, rd);
  endtask

  task automatic kw(input logic [7:0] k, input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, KEY, k);
    apb(1'b1, idx, d);
    repeat (3) @(posedge clk);
  endtask

  // Hang guard: a run that never ends is a failure.
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    $display("BAD run expected end seen timeout");
    conclude();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    st = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    rdc("pwr", PWR, 8'h82);
    chk("core_div", 8'h02, {5'h0, ctl.core_div});
    rdc("key", KEY, 8'h00);
    rdc("peripheral_config_status", PER, 8'h60);
    apb(1'b0, 8'h10, 8'h00);
    chk("pslverr", 8'h01, {7'h0, err});
    $display("test reset done");
    // Divider codes and metering rate over 128 PLL ticks each.
    for (int d = 0; d < 8; d++) begin
      kw(clk_pwr_pkg::KEY_POWER, PWR, 8'(d));
      rdc("pwr", PWR, 8'h80 | 8'(d));
      chk("core_div", 8'(d), {5'h0, ctl.core_div});
      c0 = core_n;
      m0 = meter_n;
      repeat (1280) @(posedge clk);
      rng("core_pulses", 128 >> d, core_n - c0);
      rng("meter_pulses", 26, meter_n - m0);
    end
    $display("test divider done");
    // Metering off, then unkeyed and stale-key writes ignored.
    kw(clk_pwr_pkg::KEY_POWER, PWR, 8'h42);
    m0 = meter_n;
    repeat (300) @(posedge clk);
    chk("metering_shutdown", 8'h01, {7'h0, ctl.metering_shutdown});
    chk("meter_pulses", 8'h00, 8'(meter_n - m0));
    apb(1'b1, PWR, 8'h02);
    rdc("pwr", PWR, 8'hC2);
    apb(1'b1, KEY, clk_pwr_pkg::KEY_POWER);
    apb(1'b1, MSK, 8'h00);
    apb(1'b1, PWR, 8'h02);
    rdc("pwr", PWR, 8'hC2);
    kw(clk_pwr_pkg::KEY_TIME, PWR, 8'h02);
    rdc("pwr", PWR, 8'hC2);
    apb(1'b1, KEY, clk_pwr_pkg::KEY_POWER);
    rdc("key", KEY, clk_pwr_pkg::KEY_POWER);
    apb(1'b1, PWR, 8'h12);
    rdc("pwr", PWR, 8'h92);
    $display("test key done");
    // Core shutdown only in battery mode.
    for (int b = 0; b < 3; b++) begin
      st.battery_mode <= (b == 1);
      repeat (4) @(posedge clk);
      chk("core_off", 8'(b == 1), {7'h0, ctl.core_off});
    end
    kw(clk_pwr_pkg::KEY_POWER, PWR, 8'h02);
    $display("test core off done");
    // Lock loss: core reset, fault flag, interrupt, acknowledge.
    st.pll_locked <= 1'b0;
    repeat (4) @(posedge clk);
    chk("core_reset", 8'h01, {7'h0, ctl.core_reset});
    chk("irq", 8'h00, {7'h0, irq});
    st.pll_locked <= 1'b1;
    repeat (4) @(posedge clk);
    chk("core_reset", 8'h00, {7'h0, ctl.core_reset});
    rdc("peripheral_config_status", PER, 8'h70);
    apb(1'b1, clk_pwr_pkg::ADC_START_REGISTER_IDX, 8'h7F);
    rdc("peripheral_config_status", PER, 8'h70);
    apb(1'b1, clk_pwr_pkg::ADC_START_REGISTER_IDX, 8'h80);
    rdc("peripheral_config_status", PER, 8'h60);
    apb(1'b1, MSK, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq", 8'h01, {7'h0, irq});
    apb(1'b1, STA, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq", 8'h00, {7'h0, irq});
    st.main_ok <= 1'b0;
    st.main_supply <= 1'b0;
    rdc("peripheral_config_status", PER, 8'h00);
    rdc("status", STA, 8'h04);
    st.main_ok <= 1'b1;
    st.main_supply <= 1'b1;
    apb(1'b1, STA, 8'h07);
    $display("test lock done");
    // Receive pin functions, reference enable and wake flag.
    for (int f = 0; f < 4; f++) begin
      if (f == 2) continue;
      w = (f == 3);
      apb(1'b1, PER, 8'h08 | 8'(f));
      repeat (2) @(posedge clk);
      chk("rx_func", 8'(f), {6'h0, ctl.rx_func});
      chk("ref_sleep", 8'h01, {7'h0, ctl.ref_sleep_en});
      st.sleep_mode <= 1'b1;
      st.rx_edge <= 1'b1;
      @(posedge clk);
      st.rx_edge <= 1'b0;
      st.sleep_mode <= 1'b0;
      repeat (2) @(posedge clk);
      rdc("peripheral_config_status", PER, {w, 7'h68} | 8'(f));
      apb(1'b1, PER, 8'h00);
    end
    $display("test receive done");
    // Timekeeping writes pass only right after the time key.
    for (int i = 0; i < 5; i++) begin
      ix = (i == 4) ? clk_pwr_pkg::INTPIN_IDX : clk_pwr_pkg::HUND_IDX + 8'(i);
      c0 = tw_n;
      apb(1'b1, ix, 8'h11);
      kw(clk_pwr_pkg::KEY_POWER, ix, 8'h22);
      chk("time_writes", 8'h00, 8'(tw_n - c0));
      kw(clk_pwr_pkg::KEY_TIME, ix, 8'h80 | 8'(i));
      chk("time_writes", 8'h01, 8'(tw_n - c0));
      chk("time_idx", ix, tw_idx);
      chk("time_data", 8'h80 | 8'(i), tw_dat);
      apb(1'b1, KEY, 8'h00);
    end
    rdc("pin_cfg", clk_pwr_pkg::INTPIN_IDX, 8'h84);
    $display("test timekeeping done");
    conclude();
  end
endmodule

`default_nettype wire
